// ---- prog_datapath.sv ----
// Programmable 8-bit datapath slice with dynamic configuration memory.
// Assumes synchronous inputs on mclk and a routed config address.
//
// Function
// - The ALU is 8 bits wide and finishes each operation in one cycle.
// - The ALU offers inc, dec, add, sub, and, or, xor and pass.
// - Pass forwards operand A unchanged to the result and its sinks.
// - Both accumulators are ALU sources, ALU sinks and compare inputs.
// - Both operand registers feed ALU and compare but never take results.
// - Compare logic flags equal and less-than between the two operands.
// - Each queue holds four bytes and links the bus to the datapath.
// - Queues load accumulators and operand regs or capture data: acc0/ALU into queue 0, ALU only into queue 1.
// - All six working registers are readable and writable by the bus.
// - An eight-entry by 16-bit memory holds the configurations.
// - The selected configuration entry steers the datapath every cycle.
// - The datapath has its own clock gate apart from other subblocks.
`timescale 1ns/1ps
module prog_datapath
  import dp_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  nrst,
  input  wire logic                  ce,
  input  wire logic                  dp_clk_en,
  input  wire logic [CFG_AW-1:0]     cfg_addr,
  input  wire logic                  cfg_wr,
  input  wire logic [CFG_AW-1:0]     cfg_waddr,
  input  wire logic [CFG_W-1:0]      cfg_wdata,
  input  wire logic                  bus_wr,
  input  wire logic                  bus_rd,
  input  wire logic [REG_AW-1:0]     bus_addr,
  input  wire logic [DATA_W-1:0]     bus_wdata,
  output logic      [DATA_W-1:0]     bus_rdata,
  output logic                       bus_rvalid,
  output logic      [DATA_W-1:0]     alu_out,
  output logic                       carry_out,
  output logic                       zero_out,
  output logic                       cmp_eq,
  output logic                       cmp_lt,
  output logic      [NUM_QUEUES-1:0] queue_empty,
  output logic      [NUM_QUEUES-1:0] queue_full
);
  import dp_pkg::*;

  // ****************************************
  // Configuration memory
  // ****************************************
  logic [CFG_W-1:0]  cfg_ram [CFG_DEPTH];
  logic [CFG_W-1:0]  cfg;
  logic              run;
  alu_func_t         func;
  operand_sel_t      sel_a;
  operand_sel_t      sel_b;
  acc_load_t         acc0_load;
  acc_load_t         acc1_load;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      for (int i = 0; i < CFG_DEPTH; i++) begin
        cfg_ram[i] <= CFG_RESET;
      end
    end else if (ce && cfg_wr) begin
      cfg_ram[cfg_waddr] <= cfg_wdata;
    end
  end

  // Address comes straight from routing each cycle
  assign cfg       = cfg_ram[cfg_addr];
  assign run       = ce && dp_clk_en;
  assign func      = alu_func_t'(cfg[CFG_FUNC_LSB +: 3]);
  assign sel_a     = operand_sel_t'(cfg[CFG_SRCA_LSB +: 2]);
  assign sel_b     = operand_sel_t'(cfg[CFG_SRCB_LSB +: 2]);
  assign acc0_load = acc_load_t'(cfg[CFG_ACC0_LSB +: 2]);
  assign acc1_load = acc_load_t'(cfg[CFG_ACC1_LSB +: 2]);

  // ****************************************
  // Working registers and operand select
  // ****************************************
  logic [DATA_W-1:0] accumulator_zero_ff;
  logic [DATA_W-1:0] accumulator_one_ff;
  logic [DATA_W-1:0] operand_reg_zero_ff;
  logic [DATA_W-1:0] operand_reg_one_ff;
  logic [DATA_W-1:0] opa;
  logic [DATA_W-1:0] opb;
  logic [DATA_W-1:0] nxt_alu;
  logic              nxt_carry;

  function automatic logic [DATA_W-1:0] pick(
    input operand_sel_t      s,
    input logic [DATA_W-1:0] a0,
    input logic [DATA_W-1:0] a1,
    input logic [DATA_W-1:0] d0,
    input logic [DATA_W-1:0] d1
  );
    case (s)
      SEL_ACC0: pick = a0;
      SEL_ACC1: pick = a1;
      SEL_OPR0: pick = d0;
      default:  pick = d1;
    endcase
  endfunction

  assign opa = pick(sel_a, accumulator_zero_ff, accumulator_one_ff,
                    operand_reg_zero_ff, operand_reg_one_ff);
  assign opb = pick(sel_b, accumulator_zero_ff, accumulator_one_ff,
                    operand_reg_zero_ff, operand_reg_one_ff);

  // ****************************************
  // ALU
  // ****************************************
  always_comb begin
    nxt_carry = 1'b0;
    case (func)
      ALU_INC: {nxt_carry, nxt_alu} = {1'b0, opa} + 9'h001;
      ALU_DEC: {nxt_carry, nxt_alu} = {1'b0, opa} - 9'h001;
      ALU_ADD: {nxt_carry, nxt_alu} = {1'b0, opa} + {1'b0, opb};
      ALU_SUB: {nxt_carry, nxt_alu} = {1'b0, opa} - {1'b0, opb};
      ALU_AND: nxt_alu = opa & opb;
      ALU_OR:  nxt_alu = opa | opb;
      ALU_XOR: nxt_alu = opa ^ opb;
      default: nxt_alu = opa;
    endcase
  end

  // ****************************************
  // Queues
  // ****************************************
  logic [NUM_QUEUES-1:0]             bus_q_wr;
  logic [NUM_QUEUES-1:0]             bus_q_rd;
  logic [NUM_QUEUES-1:0]             dp_push;
  logic [NUM_QUEUES-1:0]             dp_pop;
  logic [NUM_QUEUES-1:0]             q_empty;
  logic [NUM_QUEUES-1:0]             q_full;
  logic [NUM_QUEUES-1:0][DATA_W-1:0] dp_qdata;
  logic [NUM_QUEUES-1:0][DATA_W-1:0] q_dout;

  assign dp_pop[0]   = (acc0_load == ACC_QUEUE) || cfg[CFG_OPR0_LOAD];
  assign dp_pop[1]   = (acc1_load == ACC_QUEUE) || cfg[CFG_OPR1_LOAD];
  assign dp_push[0]  = cfg[CFG_Q0_CAP];
  assign dp_push[1]  = cfg[CFG_Q1_CAP];
  assign dp_qdata[0] = cfg[CFG_Q0_SRC] ? nxt_alu : accumulator_zero_ff;
  assign dp_qdata[1] = nxt_alu;

  for (genvar i = 0; i < NUM_QUEUES; i++) begin : g_queue
    queue_if q_if ();

    assign bus_q_wr[i] = ce && bus_wr &&
                         (bus_addr == REG_QUEUE0 + REG_AW'(i));
    assign bus_q_rd[i] = ce && bus_rd &&
                         (bus_addr == REG_QUEUE0 + REG_AW'(i));
    // Datapath capture wins over a bus write in the same cycle
    assign q_if.push   = (run && dp_push[i]) || bus_q_wr[i];
    assign q_if.din    = (run && dp_push[i]) ? dp_qdata[i] : bus_wdata;
    assign q_if.pop    = (run && dp_pop[i]) || bus_q_rd[i];
    assign q_dout[i]   = q_if.dout;
    assign q_empty[i]  = q_if.empty;
    assign q_full[i]   = q_if.full;

    queue_fifo u_fifo (
      .mclk (mclk),
      .nrst (nrst),
      .q    (q_if)
    );
  end

  // ****************************************
  // Register updates
  // ****************************************
  function automatic logic [DATA_W-1:0] acc_next(
    input acc_load_t         ld,
    input logic [DATA_W-1:0] cur,
    input logic [DATA_W-1:0] alu,
    input logic [DATA_W-1:0] qd,
    input logic              qe
  );
    case (ld)
      ACC_ALU:   acc_next = alu;
      ACC_QUEUE: acc_next = qe ? cur : qd;
      default:   acc_next = cur;
    endcase
  endfunction

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      accumulator_zero_ff <= REG_RESET;
      accumulator_one_ff  <= REG_RESET;
    end else if (ce) begin
      if (bus_wr && bus_addr == REG_ACC0) begin
        accumulator_zero_ff <= bus_wdata;
      end else if (run) begin
        accumulator_zero_ff <= acc_next(acc0_load, accumulator_zero_ff,
                               nxt_alu, q_dout[0], q_empty[0]);
      end
      if (bus_wr && bus_addr == REG_ACC1) begin
        accumulator_one_ff <= bus_wdata;
      end else if (run) begin
        accumulator_one_ff <= acc_next(acc1_load, accumulator_one_ff,
                              nxt_alu, q_dout[1], q_empty[1]);
      end
    end
  end

  // Operand registers load only from the bus or a queue
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      operand_reg_zero_ff <= REG_RESET;
      operand_reg_one_ff  <= REG_RESET;
    end else if (ce) begin
      if (bus_wr && bus_addr == REG_OPR0) begin
        operand_reg_zero_ff <= bus_wdata;
      end else if (run && cfg[CFG_OPR0_LOAD] && !q_empty[0]) begin
        operand_reg_zero_ff <= q_dout[0];
      end
      if (bus_wr && bus_addr == REG_OPR1) begin
        operand_reg_one_ff <= bus_wdata;
      end else if (run && cfg[CFG_OPR1_LOAD] && !q_empty[1]) begin
        operand_reg_one_ff <= q_dout[1];
      end
    end
  end

  // ****************************************
  // Result and compare flags
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      alu_out   <= REG_RESET;
      carry_out <= 1'b0;
      zero_out  <= 1'b0;
      cmp_eq    <= 1'b0;
      cmp_lt    <= 1'b0;
    end else if (run) begin
      alu_out   <= nxt_alu;
      carry_out <= nxt_carry;
      zero_out  <= (nxt_alu == REG_RESET);
      cmp_eq    <= (opa == opb);
      cmp_lt    <= (opa < opb);
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      queue_empty <= {NUM_QUEUES{1'b1}};
      queue_full  <= '0;
    end else if (ce) begin
      queue_empty <= q_empty;
      queue_full  <= q_full;
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  logic [DATA_W-1:0] nxt_rdata;

  always_comb begin
    nxt_rdata = REG_RESET;
    case (bus_addr)
      REG_ACC0:   nxt_rdata = accumulator_zero_ff;
      REG_ACC1:   nxt_rdata = accumulator_one_ff;
      REG_OPR0:   nxt_rdata = operand_reg_zero_ff;
      REG_OPR1:   nxt_rdata = operand_reg_one_ff;
      REG_QUEUE0: nxt_rdata = q_dout[0];
      REG_QUEUE1: nxt_rdata = q_dout[1];
      REG_STATUS: begin
        nxt_rdata[STS_Q0_EMPTY] = q_empty[0];
        nxt_rdata[STS_Q0_FULL]  = q_full[0];
        nxt_rdata[STS_Q1_EMPTY] = q_empty[1];
        nxt_rdata[STS_Q1_FULL]  = q_full[1];
      end
      default:    nxt_rdata = REG_RESET;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      bus_rdata  <= REG_RESET;
      bus_rvalid <= 1'b0;
    end else if (ce) begin
      bus_rvalid <= bus_rd;
      if (bus_rd) begin
        bus_rdata <= nxt_rdata;
      end
    end
  end
endmodule

// ---- dp_pkg.sv ----
// Constants and types for the programmable datapath slice.
// Assumes one clock domain and the documented register set.
package dp_pkg;

  // ****************************************
  // Widths and depths
  // ****************************************
  localparam int DATA_W      = 8;
  localparam int CFG_W       = 16;
  localparam int CFG_DEPTH   = 8;
  localparam int CFG_AW      = 3;
  localparam int QUEUE_DEPTH = 4;
  localparam int QUEUE_PW    = 2;
  localparam int QUEUE_CW    = 3;
  localparam int REG_AW      = 3;
  localparam int NUM_QUEUES  = 2;

  // ****************************************
  // Register indices on the working register port
  // ****************************************
  localparam logic [REG_AW-1:0] REG_ACC0   = 3'h0;
  localparam logic [REG_AW-1:0] REG_ACC1   = 3'h1;
  localparam logic [REG_AW-1:0] REG_OPR0   = 3'h2;
  localparam logic [REG_AW-1:0] REG_OPR1   = 3'h3;
  localparam logic [REG_AW-1:0] REG_QUEUE0 = 3'h4;
  localparam logic [REG_AW-1:0] REG_QUEUE1 = 3'h5;
  localparam logic [REG_AW-1:0] REG_STATUS = 3'h6;

  // ****************************************
  // Configuration word fields
  // ****************************************
  localparam int CFG_FUNC_LSB  = 0;
  localparam int CFG_SRCA_LSB  = 3;
  localparam int CFG_SRCB_LSB  = 5;
  localparam int CFG_ACC0_LSB  = 7;
  localparam int CFG_ACC1_LSB  = 9;
  localparam int CFG_OPR0_LOAD = 11;
  localparam int CFG_OPR1_LOAD = 12;
  localparam int CFG_Q0_CAP    = 13;
  localparam int CFG_Q0_SRC    = 14;
  localparam int CFG_Q1_CAP    = 15;

  // Status register bit positions
  localparam int STS_Q0_EMPTY = 0;
  localparam int STS_Q0_FULL  = 1;
  localparam int STS_Q1_EMPTY = 2;
  localparam int STS_Q1_FULL  = 3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [CFG_W-1:0]  CFG_RESET = 16'h0000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ALU_PASS, ALU_INC, ALU_DEC, ALU_ADD,
    ALU_SUB, ALU_AND, ALU_OR, ALU_XOR
  } alu_func_t;

  typedef enum logic [1:0] {
    SEL_ACC0, SEL_ACC1, SEL_OPR0, SEL_OPR1
  } operand_sel_t;

  typedef enum logic [1:0] {
    ACC_HOLD, ACC_ALU, ACC_QUEUE, ACC_RSVD
  } acc_load_t;

endpackage

// ---- queue_if.sv ----
// Interface between the datapath core and one byte queue.
// Assumes push and pop are already qualified by the clock enable.
`timescale 1ns/1ps
interface queue_if;
  logic                      push;
  logic                      pop;
  logic [dp_pkg::DATA_W-1:0] din;
  logic [dp_pkg::DATA_W-1:0] dout;
  logic                      empty;
  logic                      full;

  modport store (input push, pop, din, output dout, empty, full);
  modport user  (output push, pop, din, input dout, empty, full);
endinterface

// ---- queue_fifo.sv ----
// Four-entry byte queue with show-ahead output.
// Assumes requests already gated by the owner's clock enable.
`timescale 1ns/1ps
module queue_fifo (
  input wire logic mclk,
  input wire logic nrst,
  queue_if.store   q
);
  import dp_pkg::*;

  logic [DATA_W-1:0]   mem [QUEUE_DEPTH];
  logic [QUEUE_PW-1:0] wr_ptr_ff;
  logic [QUEUE_PW-1:0] rd_ptr_ff;
  logic [QUEUE_CW-1:0] count_ff;
  logic                do_push;
  logic                do_pop;

  // Full queue still accepts a push when a pop frees a slot
  assign do_pop  = q.pop && (count_ff != '0);
  assign do_push = q.push &&
                   (count_ff != QUEUE_CW'(QUEUE_DEPTH) || do_pop);

  assign q.dout  = mem[rd_ptr_ff];
  assign q.empty = (count_ff == '0);
  assign q.full  = (count_ff == QUEUE_CW'(QUEUE_DEPTH));

  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem[wr_ptr_ff] <= q.din;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_ff <= wr_ptr_ff + 2'h1;
      end
      if (do_pop) begin
        rd_ptr_ff <= rd_ptr_ff + 2'h1;
      end
      if (do_push && !do_pop) begin
        count_ff <= count_ff + 3'h1;
      end else if (do_pop && !do_push) begin
        count_ff <= count_ff - 3'h1;
      end
    end
  end
endmodule

// ---- dp_properties.sv ----
// Concurrent checks on the datapath slice top-level ports.
// Assumes one clock domain, mclk, with sync active-low nrst.
`timescale 1ns/1ps
module dp_properties
  import dp_pkg::*;
(
  input wire logic                          mclk,
  input wire logic                          nrst,
  input wire logic                          ce,
  input wire logic                          dp_clk_en,
  input wire logic                          bus_rd,
  input wire logic [dp_pkg::REG_AW-1:0]     bus_addr,
  input wire logic [dp_pkg::DATA_W-1:0]     bus_rdata,
  input wire logic                          bus_rvalid,
  input wire logic [dp_pkg::DATA_W-1:0]     alu_out,
  input wire logic                          zero_out,
  input wire logic                          cmp_eq,
  input wire logic                          cmp_lt,
  input wire logic [dp_pkg::NUM_QUEUES-1:0] queue_empty,
  input wire logic [dp_pkg::NUM_QUEUES-1:0] queue_full
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // ****
  // Steps
  // ****
  sequence s_read;
    ce && bus_rd;
  endsequence
  sequence s_run;
    nrst && ce && dp_clk_en;
  endsequence

  // ****
  // Checks
  // ****
  read_answer_a: assert property (s_read |=> bus_rvalid)
    else $error("read not answered next cycle");
  rvalid_cause_a: assert property (
    bus_rvalid && $past(ce) |-> $past(bus_rd))
    else $error("read valid without a taken read");
  rdata_hold_a: assert property (
    nrst && !(ce && bus_rd) |=> $stable(bus_rdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (
    s_read ##0 bus_addr == 3'h7 |=> bus_rdata == 8'h00)
    else $error("unmapped index read nonzero");
  gate_hold_a: assert property (
    nrst && ce && !dp_clk_en |=> $stable(alu_out) && $stable(cmp_eq))
    else $error("datapath moved while gated");
  zero_flag_a: assert property (
    s_run |=> zero_out == (alu_out == 8'h00))
    else $error("zero flag disagrees with result");
  cmp_excl_a: assert property (cmp_eq |-> !cmp_lt)
    else $error("equal and less both set");
  queue_status_a: assert property (
    |queue_full |-> (queue_full & queue_empty) == 2'h0)
    else $error("queue empty and full together");
  reset_state_a: assert property (
    $rose(nrst) |-> queue_empty == 2'h3 && !bus_rvalid)
    else $error("state after reset wrong");
endmodule

bind prog_datapath dp_properties i_dp_properties (.mclk, .nrst, .ce,
  .dp_clk_en, .bus_rd, .bus_addr, .bus_rdata, .bus_rvalid, .alu_out,
  .zero_out, .cmp_eq, .cmp_lt, .queue_empty, .queue_full);

// ---- host_bus_model.sv ----
// Firmware or DMA master on the working register port.
// Assumes requests are taken on rising mclk while ce is high.
`timescale 1ns/1ps
module host_bus_model (
  input wire logic                      mclk,
  input wire logic [dp_pkg::DATA_W-1:0] bus_rdata,
  input wire logic                      bus_rvalid,
  output logic                          bus_wr,
  output logic                          bus_rd,
  output logic [dp_pkg::REG_AW-1:0]     bus_addr,
  output logic [dp_pkg::DATA_W-1:0]     bus_wdata
);
  import dp_pkg::*;
  initial begin
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 3'h7;
    bus_wdata = 8'h00;
  end
  // Idle address and data flip so stale values never look valid
  task automatic wr(input logic [REG_AW-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge mclk);
    bus_wr <= 1'b0;
    bus_addr <= ~a;
    bus_wdata <= ~d;
  endtask
  task automatic rd(input logic [REG_AW-1:0] a, output logic [DATA_W-1:0] d,
                    output logic v);
    @(posedge mclk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge mclk);
    bus_rd <= 1'b0;
    bus_addr <= ~a;
    #1;
    v = bus_rvalid;
    d = bus_rdata;
  endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the datapath slice.
// Assumes host_bus_model and the bound checker are compiled before it.
`timescale 1ns/1ps
module tb_top;
  import dp_pkg::*;
  typedef struct packed {
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
    logic [DATA_W-1:0] r;
    logic              c;
  } row_t;
  logic                  mclk, nrst, ce, dp_clk_en, cfg_wr;
  logic [CFG_AW-1:0]     cfg_addr, cfg_waddr;
  logic [CFG_W-1:0]      cfg_wdata;
  logic                  bus_wr, bus_rd, bus_rvalid, carry_out;
  logic                  zero_out, cmp_eq, cmp_lt;
  logic [REG_AW-1:0]     bus_addr;
  logic [DATA_W-1:0]     bus_wdata, bus_rdata, alu_out;
  logic [NUM_QUEUES-1:0] queue_empty, queue_full;
  logic [3:0]            flags;
  int                    n_fail = 0;
  int                    num_checks = 0;
  // Rows indexed by function code: pass inc dec add sub and or xor
  row_t rows [8] = '{
    '{8'h33, 8'h33, 8'h33, 1'b0}, '{8'hff, 8'h00, 8'h00, 1'b1},
    '{8'h00, 8'h00, 8'hff, 1'b1}, '{8'hf0, 8'h20, 8'h10, 1'b1},
    '{8'h10, 8'h20, 8'hf0, 1'b1}, '{8'hf0, 8'h3c, 8'h30, 1'b0},
    '{8'hf0, 8'h0f, 8'hff, 1'b0}, '{8'haa, 8'hff, 8'h55, 1'b0}};

  prog_datapath i_prog_datapath (.mclk, .nrst, .ce, .dp_clk_en, .cfg_addr,
    .cfg_wr, .cfg_waddr, .cfg_wdata, .bus_wr, .bus_rd, .bus_addr, .bus_wdata,
    .bus_rdata, .bus_rvalid, .alu_out, .carry_out, .zero_out, .cmp_eq,
    .cmp_lt, .queue_empty, .queue_full);
  host_bus_model i_host (.mclk, .bus_rdata, .bus_rvalid, .bus_wr, .bus_rd,
    .bus_addr, .bus_wdata);

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ****
  // Helpers
  // ****
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bits(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [REG_AW-1:0] a, input logic [7:0] exp);
    logic [DATA_W-1:0] d;
    logic              v;
    i_host.rd(a, d, v);
    chk_bits({3'h0, v}, 4'h1);
    chk_byte(d, exp);
  endtask
  task automatic cfg(input logic [CFG_AW-1:0] k, input logic [CFG_W-1:0] w);
    @(posedge mclk);
    cfg_wr <= 1'b1;
    cfg_waddr <= k;
    cfg_wdata <= w;
    @(posedge mclk);
    cfg_wr <= 1'b0;
  endtask
  // One gated step; the address then moves on while gated off
  task automatic run(input logic [CFG_AW-1:0] k);
    @(posedge mclk);
    cfg_addr <= k;
    dp_clk_en <= 1'b1;
    @(posedge mclk);
    dp_clk_en <= 1'b0;
    cfg_addr <= ~k;
    #1;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge mclk);
    n_fail++;
    finish_test();
  end

  // ****
  // Tests
  // ****
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    dp_clk_en = 1'b0;
    cfg_addr = 3'h0;
    cfg_wr = 1'b0;
    cfg_waddr = 3'h0;
    cfg_wdata = 16'h0000;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    #1;
    chk_bits({2'h0, queue_empty}, 4'h3);
    rd_chk(REG_ACC0, REG_RESET);
    rd_chk(REG_STATUS, 8'h05);
    $display("test reset done");
    for (int i = 0; i < 8; i++) cfg(i[2:0], 16'h0240 | 16'(i));
    for (int i = 0; i < 8; i++) begin
      i_host.wr(REG_ACC0, rows[i].a);
      i_host.wr(REG_OPR0, rows[i].b);
      run(i[2:0]);
      chk_byte(alu_out, rows[i].r);
      if (i >= 1 && i <= 4) begin
        chk_bits({3'h0, carry_out}, {3'h0, rows[i].c});
      end
      flags = {1'b0, rows[i].r == 8'h00, rows[i].a == rows[i].b,
               rows[i].a < rows[i].b};
      chk_bits({1'b0, zero_out, cmp_eq, cmp_lt}, flags);
      rd_chk(REG_ACC1, rows[i].r);
      rd_chk(REG_OPR0, rows[i].b);
      chk_byte(alu_out, rows[i].r);
    end
    $display("test alu done");
    // Fifth write must be dropped
    for (int j = 0; j < 5; j++) begin
      i_host.wr(REG_QUEUE0, 8'h10 + 8'(j));
    end
    @(posedge mclk);
    #1;
    chk_bits({queue_empty, queue_full}, 4'h9);
    rd_chk(REG_STATUS, 8'h06);
    for (int j = 0; j < 4; j++) rd_chk(REG_QUEUE0, 8'h10 + 8'(j));
    rd_chk(REG_STATUS, 8'h05);
    $display("test queue done");
    i_host.wr(REG_QUEUE0, 8'h11);
    i_host.wr(REG_QUEUE0, 8'h22);
    i_host.wr(REG_ACC0, 8'h77);
    cfg(3'h1, 16'h8100);
    run(3'h1);
    run(3'h1);
    rd_chk(REG_ACC0, 8'h22);
    rd_chk(REG_QUEUE1, 8'h77);
    rd_chk(REG_QUEUE1, 8'h11);
    $display("test queue path done");
    // Operand reg pops queue1 while acc0 is captured into queue0
    i_host.wr(REG_QUEUE1, 8'h3c);
    cfg(3'h2, 16'h303b);
    run(3'h2);
    chk_byte(alu_out, 8'h55);
    chk_bits({1'b0, zero_out, cmp_eq, cmp_lt}, 4'h1);
    chk_bits({3'h0, carry_out}, 4'h0);
    rd_chk(REG_OPR1, 8'h3c);
    rd_chk(REG_QUEUE0, 8'h22);
    rd_chk(REG_ACC1, 8'h55);
    rd_chk(REG_STATUS, 8'h05);
    $display("test operand load done");
    @(posedge mclk);
    ce <= 1'b0;
    i_host.wr(REG_ACC0, 8'h99);
    @(posedge mclk);
    ce <= 1'b1;
    rd_chk(REG_ACC0, 8'h22);
    i_host.wr(3'h7, 8'h5a);
    rd_chk(3'h7, 8'h00);
    @(posedge mclk);
    nrst <= 1'b0;
    @(posedge mclk);
    nrst <= 1'b1;
    rd_chk(REG_ACC0, REG_RESET);
    $display("test freeze and reset done");
    finish_test();
  end
endmodule
